// ==== hdl/hc_regs_pkg.sv ====
package hc_regs_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_AREA_PENDING = 12'h0334;
    localparam logic [11:0] ADDR_DONE_TIMEOUT = 12'h0338;
    localparam logic [11:0] ADDR_READ_POINTER = 12'h033C;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h0340;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h0344;
    localparam logic [11:0] ADDR_AREA_BUSY = 12'h0348;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_ASYNC = 0;
    localparam int BIT_INTR = 1;
    localparam int BIT_ISO = 2;
    localparam int PENDING_W = 3;
    localparam int BANK_LSB = 16;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 16;
    localparam int NUM_BANKS = 4;
    localparam logic [31:0] TIMEOUT_RESET = 32'h0000_0000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;

    // Interrupt status bits
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_W = 1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AREA_ISO = 2'b00,
        AREA_INTR = 2'b01,
        AREA_ASYNC = 2'b10
    } area_e;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } mem_req_s;

endpackage

// ==== hdl/ms_tick.sv ====
`timescale 1ns/1ps
// Divider giving a one-cycle enable once per millisecond
module ms_tick
    import hc_regs_pkg::*;
#(
    parameter int DIVIDE = CYCLES_PER_MS
) (
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic clear_i,
    output logic tick_o
);
    logic [31:0] count;
    wire logic at_end = (count == 32'(DIVIDE - 1));

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            count <= 32'h0000_0000;
        end else if (clear_i || at_end) begin
            count <= 32'h0000_0000;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end

    assign tick_o = at_end && !clear_i;
endmodule // ms_tick

// ==== hdl/hc_buffer_status_mem_read_regs.sv ====
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Contract
// - Iso flag bit 2 gates iso area
// - Interrupt flag bit 1 gates interrupt area
// - Async flag bit 0 gates async area
// - 32-bit ms timeout raises interrupt
// - Timeout applies to async completions only
// - Bits 17:16 select one of four banks
// - Bits 15:0 give read start address
// - Write latches; each bank read increments
// - Walk only valid, unskipped descriptors
module hc_buffer_status_mem_read_regs
    import hc_regs_pkg::*;
#(
    parameter int MS_DIVIDE = CYCLES_PER_MS,
    parameter int DESC_IDX_W = 5
) (
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Schedule engine: descriptor walk
    input wire logic AREA_DONE_I,
    input wire logic DESC_VALID_I,
    input wire logic DESC_SKIP_I,
    input wire logic ASYNC_DESC_DONE_I,
    input wire logic INTR_DESC_DONE_I,
    input wire logic ISO_DESC_DONE_I,
    output logic WALK_ACTIVE_O,
    output logic [1:0] WALK_AREA_O,
    output logic [DESC_IDX_W-1:0] DESC_INDEX_O,
    output logic DESC_EXECUTE_O,
    // Memory port: PIO read strobe
    input wire logic PIO_READ_I,
    input wire logic [1:0] PIO_READ_BANK_I,
    output logic [1:0] MEM_BANK_O,
    output logic [15:0] MEM_ADDR_O,
    output logic IRQ_O
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic wr = PSEL_I && PENABLE_I && PWRITE_I;
    wire logic rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
    wire logic hit_pend = (PADDR_I == ADDR_AREA_PENDING);
    wire logic hit_tmo = (PADDR_I == ADDR_DONE_TIMEOUT);
    wire logic hit_ptr = (PADDR_I == ADDR_READ_POINTER);
    wire logic hit_sts = (PADDR_I == ADDR_IRQ_STATUS);
    wire logic hit_msk = (PADDR_I == ADDR_IRQ_MASK);
    wire logic hit_busy = (PADDR_I == ADDR_AREA_BUSY);
    wire logic mapped = hit_pend || hit_tmo || hit_ptr || hit_sts || hit_msk || hit_busy;
    wire logic wr_pend = wr && hit_pend;
    wire logic wr_tmo = wr && hit_tmo;
    wire logic wr_msk = wr && hit_msk;
    wire logic wr_sts = wr && hit_sts;

    // Every register answers in its first access cycle, so no wait states
    assign PREADY_O = 1'b1;
    // Unmapped offsets answer with an error and leave every register alone
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [PENDING_W-1:0] area_pending;
    logic [31:0] async_done_timeout_ms;
    logic [BANK_W-1:0] sel_bank;
    logic [ADDR_W-1:0] bank_ptr [NUM_BANKS];
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    // Reserved bits are neither stored nor checked; they read as zero
    // reserved dropped
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            area_pending <= '0;
        end else if (wr_pend) begin
            area_pending <= PWDATA_I[PENDING_W-1:0];
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            async_done_timeout_ms <= TIMEOUT_RESET;
        end else if (wr_tmo) begin
            async_done_timeout_ms <= PWDATA_I;
        end
    end

    // Mask bits share the status layout
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            irq_mask <= '0;
        end else if (wr_msk) begin
            irq_mask <= PWDATA_I[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Bank read pointers
    // ------------------------------------------------------------
    // start address written
    wire logic ptr_wr = wr && hit_ptr;
    wire logic [BANK_W-1:0] wr_bank = PWDATA_I[BANK_LSB +: BANK_W];

    // A same-bank write wins over a read in one cycle
    // Pointers wrap from the top address to zero unflagged
    // one pointer per bank
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            wire logic load = ptr_wr && (wr_bank == BANK_W'(b));
            wire logic step = PIO_READ_I && (PIO_READ_BANK_I == BANK_W'(b));
            always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    bank_ptr[b] <= ADDR_RESET;
                end else if (load) begin
                    bank_ptr[b] <= PWDATA_I[ADDR_W-1:0];
                end else if (step) begin
                    bank_ptr[b] <= bank_ptr[b] + 16'h0001;
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sel_bank <= '0;
        end else if (ptr_wr) begin
            sel_bank <= wr_bank;
        end
    end

    // Idle cycles show the selected bank's pointer
    wire logic [BANK_W-1:0] show_bank = PIO_READ_I ? PIO_READ_BANK_I : sel_bank;
    wire logic [ADDR_W-1:0] show_addr = bank_ptr[show_bank];

    // address presented for the read under way
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            MEM_BANK_O <= '0;
            MEM_ADDR_O <= ADDR_RESET;
        end else begin
            MEM_BANK_O <= show_bank;
            MEM_ADDR_O <= show_addr;
        end
    end

    // ------------------------------------------------------------
    // Descriptor area walk
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WALK = 2'b01
    } walk_e;

    walk_e state;
    walk_e next_state;
    area_e area;
    area_e next_area;
    logic [DESC_IDX_W-1:0] desc_index;

    function automatic logic area_on(input area_e a, input logic [PENDING_W-1:0] p);
        case (a)
            AREA_ISO: area_on = p[BIT_ISO];
            AREA_INTR: area_on = p[BIT_INTR];
            AREA_ASYNC: area_on = p[BIT_ASYNC];
            default: area_on = 1'b0;
        endcase
    endfunction

    function automatic area_e area_after(input area_e a);
        case (a)
            AREA_ISO: area_after = AREA_INTR;
            AREA_INTR: area_after = AREA_ASYNC;
            default: area_after = AREA_ISO;
        endcase
    endfunction

    wire logic cur_on = area_on(area, area_pending);
    wire logic last_desc = (desc_index == {DESC_IDX_W{1'b1}});
    // The index limit ends a walk whose engine never reports done
    // A cleared flag ends a walk at once, even in mid-area
    wire logic area_end = AREA_DONE_I || last_desc || !cur_on;

    always_comb begin
        next_state = state;
        next_area = area;
        case (state)
            ST_IDLE: begin
                if (cur_on) begin
                    next_state = ST_WALK;
                end else begin
                    next_area = area_after(area);
                end
            end
            ST_WALK: begin
                if (area_end) begin
                    next_state = ST_IDLE;
                    next_area = area_after(area);
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state <= ST_IDLE;
            area <= AREA_ISO;
            desc_index <= '0;
        end else begin
            state <= next_state;
            area <= next_area;
            if (state != ST_WALK || area_end) begin
                desc_index <= '0;
            end else begin
                desc_index <= desc_index + 1'b1;
            end
        end
    end

    assign WALK_ACTIVE_O = (state == ST_WALK);
    assign WALK_AREA_O = area;
    assign DESC_INDEX_O = desc_index;
    assign DESC_EXECUTE_O = (state == ST_WALK) && cur_on && DESC_VALID_I && !DESC_SKIP_I;

    // ------------------------------------------------------------
    // Async completion timeout
    // ------------------------------------------------------------
    logic ms_tick_en;
    logic [31:0] ms_count;
    logic tmo_armed;

    // Interrupt and iso completions are left out on purpose
    // async only
    wire logic async_done = ASYNC_DESC_DONE_I;
    wire logic tmo_zero = (async_done_timeout_ms == TIMEOUT_RESET);
    // One-shot: a completion while armed does not restart the count
    // A zero time-out never arms; zero written while armed fires at the next tick
    wire logic tmo_arm = async_done && !tmo_armed && !tmo_zero;
    // Restarting the divider on arming makes the first millisecond whole
    wire logic ms_restart = async_done && !tmo_armed;
    wire logic tmo_fire = tmo_armed && ms_tick_en &&
                          (ms_count + 32'h0000_0001 >= async_done_timeout_ms);

    ms_tick #(
        .DIVIDE(MS_DIVIDE)
    ) u_ms_tick (
        .MCLK_I(MCLK_I),
        .RESET_N_I(RESET_N_I),
        .clear_i(ms_restart),
        .tick_o(ms_tick_en)
    );

    // count ms after an async completion
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tmo_armed <= 1'b0;
            ms_count <= 32'h0000_0000;
        end else if (tmo_fire) begin
            tmo_armed <= 1'b0;
            ms_count <= 32'h0000_0000;
        end else if (tmo_arm) begin
            tmo_armed <= 1'b1;
            ms_count <= 32'h0000_0000;
        end else if (tmo_armed && ms_tick_en) begin
            ms_count <= ms_count + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Set wins over a write-one clear in the same cycle
    wire logic [IRQ_W-1:0] irq_set = IRQ_W'(tmo_fire) << IRQ_TIMEOUT;
    wire logic [IRQ_W-1:0] irq_clr = wr_sts ? PWDATA_I[IRQ_W-1:0] : '0;
    wire logic [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign IRQ_O = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_value;

    always_comb begin
        rd_value = 32'h0000_0000;
        if (hit_pend) begin
            rd_value = {29'h0, area_pending};
        end else if (hit_tmo) begin
            rd_value = async_done_timeout_ms;
        end else if (hit_ptr) begin
            rd_value = {14'h0, sel_bank, bank_ptr[sel_bank]};
        end else if (hit_sts) begin
            rd_value = {31'h0, irq_status};
        end else if (hit_msk) begin
            rd_value = {31'h0, irq_mask};
        end else if (hit_busy) begin
            // Walk status: bit 2 busy, bits 1:0 area under way
            rd_value = {29'h0, WALK_ACTIVE_O, area};
        end
    end

    // Captured in the setup cycle; holds until the next read
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (rd_setup) begin
            PRDATA_O <= rd_value;
        end
    end

    // Unused completion inputs kept for the engine's port set
    wire logic unused_done = INTR_DESC_DONE_I ^ ISO_DESC_DONE_I;
endmodule // hc_buffer_status_mem_read_regs

// ==== tb/hc_regs_properties.sv ====
`timescale 1ns/1ps
module hc_regs_properties
    import hc_regs_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic DESC_VALID_I,
    input wire logic DESC_SKIP_I,
    input wire logic WALK_ACTIVE_O,
    input wire logic [1:0] WALK_AREA_O,
    input wire logic [4:0] DESC_INDEX_O,
    input wire logic DESC_EXECUTE_O,
    input wire logic PIO_READ_I,
    input wire logic [1:0] PIO_READ_BANK_I,
    input wire logic [1:0] MEM_BANK_O,
    input wire logic [15:0] MEM_ADDR_O,
    input wire logic IRQ_O
);
    // ----------------------------------------
    // Shadow of what software has written, with pointers stepped by PIO reads
    // ----------------------------------------
    logic [2:0] pend;
    logic mask;
    logic [15:0] ptr [NUM_BANKS];
    wire wr = PSEL_I & PENABLE_I & PWRITE_I;
    wire wr_ptr = wr && PADDR_I == ADDR_READ_POINTER;
    wire mapped = PADDR_I inside {ADDR_AREA_PENDING, ADDR_DONE_TIMEOUT, ADDR_READ_POINTER,
        ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_AREA_BUSY};
    // A same-bank write wins over the read, so that cycle is left out
    wire clash = wr_ptr && PWDATA_I[17:16] == PIO_READ_BANK_I;
    wire [15:0] cur_ptr = ptr[PIO_READ_BANK_I];
    wire flag = WALK_AREA_O == AREA_ISO ? pend[BIT_ISO] : WALK_AREA_O == AREA_INTR ?
        pend[BIT_INTR] : WALK_AREA_O == AREA_ASYNC ? pend[BIT_ASYNC] : 1'b0;
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pend <= 3'h0;
            mask <= 1'b0;
            for (int b = 0; b < NUM_BANKS; b++) ptr[b] <= ADDR_RESET;
        end else begin
            if (wr && PADDR_I == ADDR_AREA_PENDING) pend <= PWDATA_I[2:0];
            if (wr && PADDR_I == ADDR_IRQ_MASK) mask <= PWDATA_I[IRQ_TIMEOUT];
            if (PIO_READ_I) ptr[PIO_READ_BANK_I] <= cur_ptr + 16'h0001;
            if (wr_ptr) ptr[PWDATA_I[17:16]] <= PWDATA_I[15:0];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking dcb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    AST_READY: assert property (PREADY_O) else $error("ready dropped");
    AST_ISO_GATE: assert property (DESC_EXECUTE_O && WALK_AREA_O == AREA_ISO |-> pend[BIT_ISO])
        else $error("iso area run with flag clear");
    AST_INTR_GATE: assert property (DESC_EXECUTE_O && WALK_AREA_O == AREA_INTR |-> pend[BIT_INTR])
        else $error("interrupt area run with flag clear");
    AST_ASYNC_GATE: assert property (DESC_EXECUTE_O && WALK_AREA_O == AREA_ASYNC |-> pend[0])
        else $error("async area run with flag clear");
    AST_EXEC_COND: assert property (DESC_EXECUTE_O == (WALK_ACTIVE_O && flag && DESC_VALID_I && !DESC_SKIP_I))
        else $error("descriptor execute wrong");
    AST_ERR_MAP: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == !mapped)
        else $error("error response wrong");
    AST_PEND_READ: assert property (PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == ADDR_AREA_PENDING |-> PRDATA_O == {29'h0, pend})
        else $error("pending readback wrong");
    AST_IRQ_MASK: assert property (!mask |-> !IRQ_O)
        else $error("interrupt while disabled");
    AST_PTR_READ: assert property (PIO_READ_I && !clash |=> MEM_BANK_O == $past(PIO_READ_BANK_I) && MEM_ADDR_O == $past(cur_ptr))
        else $error("read address wrong");
    AST_BANK_SEL: assert property (wr_ptr && !PIO_READ_I ##1 !PIO_READ_I [*2] |-> MEM_BANK_O == $past(PWDATA_I[17:16], 2) && MEM_ADDR_O == $past(PWDATA_I[15:0], 2))
        else $error("bank select wrong");
    AST_INDEX_IDLE: assert property (!WALK_ACTIVE_O |-> DESC_INDEX_O == 5'h00)
        else $error("descriptor index not cleared when idle");
    AST_INDEX_STEP: assert property (WALK_ACTIVE_O && $past(WALK_ACTIVE_O) |-> DESC_INDEX_O == $past(DESC_INDEX_O) + 5'h01)
        else $error("descriptor index did not step");
    AST_COV_EXEC: cover property (DESC_EXECUTE_O);
    AST_COV_IRQ: cover property (IRQ_O);
    AST_COV_PIO: cover property (PIO_READ_I);
endmodule // hc_regs_properties

bind hc_buffer_status_mem_read_regs hc_regs_properties u_props (.MCLK_I, .RESET_N_I, .PSEL_I,
    .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .DESC_VALID_I,
    .DESC_SKIP_I, .WALK_ACTIVE_O, .WALK_AREA_O, .DESC_INDEX_O, .DESC_EXECUTE_O, .PIO_READ_I,
    .PIO_READ_BANK_I,
    .MEM_BANK_O, .MEM_ADDR_O, .IRQ_O);

// ==== tb/sched_engine_model.sv ====
`timescale 1ns/1ps
module sched_engine_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic walk_active_i,
    input wire logic [3:0] lat_i,
    input wire logic valid_i,
    input wire logic skip_i,
    output logic area_done_o,
    output logic desc_valid_o,
    output logic desc_skip_o
);
    logic [3:0] cnt;
    logic churn;
    // header lines churn when no walk
    assign desc_valid_o = walk_active_i ? valid_i : churn;
    assign desc_skip_o = walk_active_i ? skip_i : ~churn;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 4'h0;
            churn <= 1'b0;
            area_done_o <= 1'b0;
        end else begin
            churn <= ~churn;
            area_done_o <= walk_active_i && cnt == lat_i && !area_done_o;
            cnt <= (walk_active_i && cnt != lat_i) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule // sched_engine_model

// ==== tb/hc_buffer_status_mem_read_regs_tb_top.sv ====
`timescale 1ns/1ps
module hc_buffer_status_mem_read_regs_tb_top;
    import hc_regs_pkg::*;
    // Short millisecond keeps the timeout run brief
    localparam int MSD = 10;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, vld = 1, skp = 0;
    logic async_done = 0, intr_done = 0, iso_done = 0, pio_rd = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rdata, prdata;
    logic perr, pslverr, pready, walk_active, desc_exec, area_done, desc_valid, desc_skip, irq;
    logic [1:0] pio_bank = 2'h0, walk_area, mem_bank;
    logic [15:0] mem_addr;
    logic [3:0] lat = 4'h2;
    int failures = 0, samples_checked = 0;
    always #50 mclk = ~mclk;
    hc_buffer_status_mem_read_regs #(.MS_DIVIDE(MSD)) dut_u (
        .MCLK_I(mclk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .AREA_DONE_I(area_done), .DESC_VALID_I(desc_valid),
        .DESC_SKIP_I(desc_skip), .ASYNC_DESC_DONE_I(async_done), .INTR_DESC_DONE_I(intr_done),
        .ISO_DESC_DONE_I(iso_done), .WALK_ACTIVE_O(walk_active), .WALK_AREA_O(walk_area),
        .DESC_INDEX_O(), .DESC_EXECUTE_O(desc_exec), .PIO_READ_I(pio_rd),
        .PIO_READ_BANK_I(pio_bank), .MEM_BANK_O(mem_bank), .MEM_ADDR_O(mem_addr), .IRQ_O(irq));
    sched_engine_model eng_u (.clk_i(mclk), .rst_n_i(rst_n), .walk_active_i(walk_active),
        .lat_i(lat), .valid_i(vld), .skip_i(skp), .area_done_o(area_done),
        .desc_valid_o(desc_valid), .desc_skip_o(desc_skip));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            failures++;
            $display("mismatch at %0t: no ready", $time);
            complete_run();
        end
    endtask
    task automatic rd(input logic [1:0] b, input logic [15:0] a);
        @(posedge mclk);
        pio_rd <= 1'b1;
        pio_bank <= b;
        @(posedge mclk);
        pio_rd <= 1'b0;
        @(negedge mclk);
        chk({14'h0, mem_bank, mem_addr}, {14'h0, b, a}, "read address");
    endtask
    task automatic pulse_async();
        @(posedge mclk);
        async_done <= 1'b1;
        @(posedge mclk);
        async_done <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, ADDR_DONE_TIMEOUT, 32'h0);
        chk(rdata, TIMEOUT_RESET, "timeout reset");
        apb(1'b1, ADDR_DONE_TIMEOUT, 32'hA5C3_0F81);
        apb(1'b0, ADDR_DONE_TIMEOUT, 32'h0);
        chk(rdata, 32'hA5C3_0F81, "timeout rw");
        apb(1'b0, 12'hFF0, 32'h0);
        chk(32'(perr), 32'h1, "unmapped error");
        $display("t_regs done");
    endtask
    task automatic t_walk();
        int cnt [4];
        logic [2:0] flags;
        for (int k = 0; k < 6; k++) begin
            flags = k < 4 ? 3'h4 >> k : 3'h7;
            lat <= 4'(k * 3);
            {vld, skp} <= k == 4 ? 2'h3 : k == 5 ? 2'h0 : 2'h2;
            apb(1'b1, ADDR_AREA_PENDING, {29'h0, flags});
            apb(1'b0, ADDR_AREA_PENDING, 32'h0);
            chk(rdata, {29'h0, flags}, "pending readback");
            cnt = '{0, 0, 0, 0};
            repeat (60) begin
                @(negedge mclk);
                if (desc_exec === 1'b1) cnt[walk_area]++;
            end
            for (int a = 0; a < 3; a++) chk(32'(cnt[a] > 0), 32'(k < 4 && flags[2-a]), "walk");
        end
        {vld, skp} <= 2'h2;
        $display("t_walk done");
    endtask
    task automatic t_timeout();
        int n;
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, ADDR_DONE_TIMEOUT, 32'h2);
        @(posedge mclk);
        {iso_done, intr_done} <= 2'h3;
        @(posedge mclk);
        {iso_done, intr_done} <= 2'h0;
        repeat (50) @(posedge mclk);
        chk(32'(irq), 32'h0, "no timeout from other areas");
        pulse_async();
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (irq !== 1'b1 && n < 100);
        // Two milliseconds after the edge that took the completion
        chk(32'(n), 32'(2 * MSD + 1), "timeout delay");
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk(rdata, 32'h1, "status set");
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        @(negedge mclk);
        chk(32'(irq), 32'h0, "status cleared");
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        pulse_async();
        repeat (40) @(posedge mclk);
        chk(32'(irq), 32'h0, "masked");
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk(rdata, 32'h1, "masked status set");
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        $display("t_timeout done");
    endtask
    task automatic t_pointer();
        for (int b = 0; b < NUM_BANKS; b++) apb(1'b1, ADDR_READ_POINTER, 32'(b) << 16 | 32'(b) << 8);
        for (int b = 0; b < NUM_BANKS; b++) rd(2'(b), 16'(b) << 8);
        rd(2'h1, 16'h0101);
        rd(2'h1, 16'h0102);
        rd(2'h2, 16'h0201);
        apb(1'b1, ADDR_READ_POINTER, 32'h0001_FFFF);
        apb(1'b0, ADDR_READ_POINTER, 32'h0);
        chk(rdata, 32'h0001_FFFF, "pointer readback");
        rd(2'h1, 16'hFFFF);
        rd(2'h3, 16'h0301);
        $display("t_pointer done");
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_walk();
        t_timeout();
        t_pointer();
        complete_run();
    end
endmodule // hc_buffer_status_mem_read_regs_tb_top
